// ### rtl/fcp_regs.svh
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH
// Byte addresses of the register map.
`define FCP_MODE_ADDR     12'h000
`define FCP_ENA_ADDR      12'h004
`define FCP_DIS_ADDR      12'h008
`define FCP_SR_ADDR       12'h00c
`define FCP_IER_ADDR      12'h010
`define FCP_IDR_ADDR      12'h014
`define FCP_IMR_ADDR      12'h018
`define FCP_ISR_ADDR      12'h01c
`define FCP_CH_BASE       12'h200
`define FCP_CH_STRIDE_LSB 5
`define FCP_CH_CMR_OFS    5'h00
`define FCP_CH_CHANNEL_DUTY_VALUE_OFS   5'h04
`define FCP_CH_CHANNEL_PERIOD_VALUE_OFS   5'h08
`define FCP_CH_CCNT_OFS   5'h0c
`define FCP_CH_CUPD_OFS   5'h10
// Generator mode fields.
`define FCP_DIVIDER_A_FACTOR_LSB      0
`define FCP_DIVIDER_A_TAP_SELECT_LSB      8
`define FCP_DIVIDER_B_FACTOR_LSB      16
`define FCP_DIVIDER_B_TAP_SELECT_LSB      24
// Channel mode fields.
`define FCP_CHANNEL_CLOCK_SELECT_LSB      0
`define FCP_CHANNEL_ALIGNMENT_BIT      8
`define FCP_CHANNEL_POLARITY_BIT      9
`define FCP_CPD_BIT       10
// Clock select codes beyond the prescaler taps.
`define FCP_SEL_DIVIDED_CLOCK_A      4'hb
`define FCP_SEL_DIVIDED_CLOCK_B      4'hc
`define FCP_NUM_TAPS      11
`define FCP_MODE_RESET    32'h0000_0000
`endif

// ### rtl/fcp_pkg.sv
package fcp_pkg;
	typedef logic [15:0] fcp_count_t;
	typedef logic [3:0]  fcp_sel_t;
	typedef enum logic [1:0] {
		FCP_UP   = 2'b00,
		FCP_DOWN = 2'b01
	} fcp_dir_t;
endpackage : fcp_pkg

// ### rtl/fcp_tick_if.sv
`timescale 1ns/10ps
// Tick enables from the clock generator to the channels.
interface fcp_tick_if;
	logic [12:0] tick;
	modport gen (output tick);
	modport chan (input tick);
endinterface : fcp_tick_if

// ### rtl/fcp_clock_gen.sv
`timescale 1ns/10ps
`include "fcp_regs.svh"
module fcp_clock_gen (
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	input  wire logic [31:0] mode_in,
	fcp_tick_if.gen          ticks
);
	logic [9:0]  presc_reg;
	logic [10:0] tap;
	logic [7:0]  cnt_a_reg;
	logic [7:0]  cnt_b_reg;
	logic        pulse_a;
	logic        pulse_b;
	logic [3:0]  pre_a;
	logic [3:0]  pre_b;
	logic [7:0]  div_a;
	logic [7:0]  div_b;
	assign pre_a = mode_in[`FCP_DIVIDER_A_TAP_SELECT_LSB +: 4];
	assign pre_b = mode_in[`FCP_DIVIDER_B_TAP_SELECT_LSB +: 4];
	assign div_a = mode_in[`FCP_DIVIDER_A_FACTOR_LSB +: 8];
	assign div_b = mode_in[`FCP_DIVIDER_B_FACTOR_LSB +: 8];

	// modulo counter prescaler. It holds while the clock is gated, so nothing drifts.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			presc_reg <= 10'h000;
		end else if (clk_en_in) begin
			presc_reg <= presc_reg + 10'h001;
		end
	end

	// divided taps idle when gated.
	// Tap i fires once every 2**i running cycles, when the low i counter bits are all ones.
	assign tap[0] = clk_en_in;
	for (genvar i = 1; i < `FCP_NUM_TAPS; i++) begin : g_tap
		assign tap[i] = clk_en_in && (&presc_reg[i-1:0]);
	end

	// tap select decode; reserved codes give no tick.
	assign pulse_a = (pre_a < 4'hb) ? tap[pre_a] : 1'b0;
	assign pulse_b = (pre_b < 4'hb) ? tap[pre_b] : 1'b0;

	// linear divider A; zero stops it.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_a_reg <= 8'h00;
		end else if (div_a == 8'h00) begin
			cnt_a_reg <= 8'h00;
		end else if (pulse_a) begin
			cnt_a_reg <= (cnt_a_reg + 8'h01 >= div_a) ? 8'h00 : cnt_a_reg + 8'h01;
		end
	end

	// linear divider B; zero stops it.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_b_reg <= 8'h00;
		end else if (div_b == 8'h00) begin
			cnt_b_reg <= 8'h00;
		end else if (pulse_b) begin
			cnt_b_reg <= (cnt_b_reg + 8'h01 >= div_b) ? 8'h00 : cnt_b_reg + 8'h01;
		end
	end

	assign ticks.tick[10:0] = tap;
	assign ticks.tick[11] = pulse_a && (div_a != 8'h00) && (cnt_a_reg + 8'h01 >= div_a);
	assign ticks.tick[12] = pulse_b && (div_b != 8'h00) && (cnt_b_reg + 8'h01 >= div_b);
endmodule : fcp_clock_gen

// ### rtl/fcp_channel.sv
`timescale 1ns/10ps
`include "fcp_regs.svh"
module fcp_channel (
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	fcp_tick_if.chan         ticks,
	input  wire logic        enable_in,
	input  wire logic [3:0]  clk_sel_in,
	input  wire logic        center_in,
	input  wire logic        polarity_in,
	input  wire logic [15:0] period_in,
	input  wire logic [15:0] duty_in,
	output logic [15:0]      count_out,
	output logic             period_end_out,
	output logic             wave_out
);
	fcp_pkg::fcp_count_t cnt_reg;
	fcp_pkg::fcp_dir_t   dir_reg;
	logic                step;
	logic                at_top;
	logic                ends;
	logic [16:0]         cnt_inc;
	logic                left_top;
	logic                past_peak;
	logic                active;
	assign step   = enable_in && (clk_sel_in < 4'hd) && ticks.tick[clk_sel_in];
	assign at_top = (cnt_reg >= period_in);
	assign cnt_inc = {1'b0, cnt_reg} + 17'h00001;
	// left mode shows counts 0 to period minus one, so a duty equal to the period never shows the active level.
	assign left_top = (cnt_inc >= {1'b0, period_in});
	// center ends at zero; left ends at period minus one.
	assign ends = step && (center_in ? (dir_reg == fcp_pkg::FCP_DOWN && cnt_reg <= 16'h0001) : left_top);
	// from the peak on the compare is one step late, so both halves hold period minus duty counts.
	assign past_peak = center_in && !(dir_reg == fcp_pkg::FCP_UP && cnt_reg < period_in);
	assign active = past_peak ? (cnt_reg > duty_in) : (cnt_reg >= duty_in);

	// counter advanced by selected clock only.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_reg <= 16'h0000;
			dir_reg <= fcp_pkg::FCP_UP;
		end else if (!enable_in) begin
			cnt_reg <= 16'h0000;
			dir_reg <= fcp_pkg::FCP_UP;
		end else if (step) begin
			if (!center_in) begin
				cnt_reg <= left_top ? 16'h0000 : cnt_inc[15:0];
			end else if (dir_reg == fcp_pkg::FCP_UP) begin
				cnt_reg <= at_top ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
				dir_reg <= at_top ? fcp_pkg::FCP_DOWN : fcp_pkg::FCP_UP;
			end else begin
				cnt_reg <= (cnt_reg == 16'h0000) ? 16'h0000 : cnt_reg - 16'h0001;
				dir_reg <= (cnt_reg <= 16'h0001) ? fcp_pkg::FCP_UP : fcp_pkg::FCP_DOWN;
			end
		end
	end

	assign period_end_out = ends;
	assign count_out = cnt_reg;

	// duty compare; polarity start level; fixed levels fall out of the compare.
	always_comb begin
		if (!enable_in) begin
			wave_out = polarity_in;
		end else if (active) begin
			wave_out = ~polarity_in;
		end else begin
			wave_out = polarity_in;
		end
	end
endmodule : fcp_channel

// ### rtl/fcp_top.sv
`timescale 1ns/10ps
`include "fcp_regs.svh"
module fcp_top #(
	parameter int NUM_CH = 4
) (
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	input  wire logic [11:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output logic             irq_out,
	output logic [3:0]       channel_wave_out
);
	logic [31:0]         generator_mode_reg;
	logic [NUM_CH-1:0]   enable_reg;
	logic [NUM_CH-1:0]   interrupt_mask_reg;
	logic [NUM_CH-1:0]   interrupt_status_reg;
	logic [10:0]         channel_mode_reg [NUM_CH];
	logic [15:0]         channel_period_reg [NUM_CH];
	logic [15:0]         channel_duty_reg [NUM_CH];
	logic [15:0]         channel_update_reg [NUM_CH];
	logic [NUM_CH-1:0]   upd_pend_reg;
	logic [15:0]         count_w [NUM_CH];
	logic [NUM_CH-1:0]   pend_w;
	logic [NUM_CH-1:0]   wave_w;
	logic [NUM_CH-1:0]   ch_hit;
	logic                gen_hit;
	logic [4:0]          ofs;
	logic                isr_rd;
	logic [31:0]         rdata_next;
	fcp_tick_if          ticks ();

	// address decode of generator and channel windows.
	assign gen_hit = (addr_in[11:5] == 7'h00);
	assign ofs = addr_in[4:0];
	assign isr_rd = rd_in && (addr_in == `FCP_ISR_ADDR);
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ch_hit[c] = (addr_in[11:`FCP_CH_STRIDE_LSB] == 7'(({20'h0, `FCP_CH_BASE} >> `FCP_CH_STRIDE_LSB) + c));
		end
	end

	fcp_clock_gen u_gen (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.clk_en_in  (clk_en_in),
		.mode_in    (generator_mode_reg),
		.ticks      (ticks)
	);

	// mode register cleared at reset; writes need no functional clock enable.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			generator_mode_reg <= `FCP_MODE_RESET;
		end else if (wr_in && addr_in == `FCP_MODE_ADDR) begin
			generator_mode_reg <= wdata_in & 32'h0fff_0fff;
		end
	end

	// Channel enable and interrupt mask set/clear pairs.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			enable_reg <= '0;
			interrupt_mask_reg <= '0;
		end else if (wr_in) begin
			if (addr_in == `FCP_ENA_ADDR) begin
				enable_reg <= enable_reg | wdata_in[NUM_CH-1:0];
			end
			if (addr_in == `FCP_DIS_ADDR) begin
				enable_reg <= enable_reg & ~wdata_in[NUM_CH-1:0];
			end
			if (addr_in == `FCP_IER_ADDR) begin
				interrupt_mask_reg <= interrupt_mask_reg | wdata_in[NUM_CH-1:0];
			end
			if (addr_in == `FCP_IDR_ADDR) begin
				interrupt_mask_reg <= interrupt_mask_reg & ~wdata_in[NUM_CH-1:0];
			end
		end
	end

	// Per-channel configuration, buffering and instances.
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic wr_here;
		logic ends;
		assign wr_here = wr_in && ch_hit[c];
		assign ends = pend_w[c] && clk_en_in;

		// clock select resets to zero; alignment default left; locked while enabled except the CPD bit.
		always_ff @(posedge mclk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				channel_mode_reg[c] <= 11'h000;
			end else if (wr_here && ofs == `FCP_CH_CMR_OFS) begin
				if (!enable_reg[c]) begin
					channel_mode_reg[c] <= wdata_in[10:0];
				end else begin
					channel_mode_reg[c][`FCP_CPD_BIT] <= wdata_in[`FCP_CPD_BIT];
				end
			end
		end

		// active period and duty change only when disabled or at period end.
		// update value transferred at period end to the selected target.
		always_ff @(posedge mclk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				channel_period_reg[c] <= 16'h0000;
				channel_duty_reg[c] <= 16'h0000;
				channel_update_reg[c] <= 16'h0000;
				upd_pend_reg[c] <= 1'b0;
			end else begin
				if (wr_here && ofs == `FCP_CH_CHANNEL_PERIOD_VALUE_OFS && !enable_reg[c]) begin
					channel_period_reg[c] <= wdata_in[15:0];
				end
				if (wr_here && ofs == `FCP_CH_CHANNEL_DUTY_VALUE_OFS && !enable_reg[c]) begin
					channel_duty_reg[c] <= wdata_in[15:0];
				end
				if (ends && upd_pend_reg[c]) begin
					if (channel_mode_reg[c][`FCP_CPD_BIT]) begin
						channel_period_reg[c] <= channel_update_reg[c];
					end else begin
						channel_duty_reg[c] <= channel_update_reg[c];
					end
				end
				if (wr_here && ofs == `FCP_CH_CUPD_OFS) begin
					channel_update_reg[c] <= wdata_in[15:0];
					upd_pend_reg[c] <= 1'b1;
				end else if (ends) begin
					upd_pend_reg[c] <= 1'b0;
				end
			end
		end

		// gating freezes the channel through its tick enables.
		fcp_channel u_ch (
			.mclk_in        (mclk_in),
			.reset_n_in     (reset_n_in),
			.ticks          (ticks),
			.enable_in      (enable_reg[c]),
			.clk_sel_in     (channel_mode_reg[c][`FCP_CHANNEL_CLOCK_SELECT_LSB +: 4]),
			.center_in      (channel_mode_reg[c][`FCP_CHANNEL_ALIGNMENT_BIT]),
			.polarity_in    (channel_mode_reg[c][`FCP_CHANNEL_POLARITY_BIT]),
			.period_in      (channel_period_reg[c]),
			.duty_in        (channel_duty_reg[c]),
			.count_out      (count_w[c]),
			.period_end_out (pend_w[c]),
			.wave_out       (wave_w[c])
		);
	end

	// sticky period flags; a new event wins over the clearing read.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			interrupt_status_reg <= '0;
		end else begin
			interrupt_status_reg <= (isr_rd ? '0 : interrupt_status_reg) | pend_w;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(((isr_rd ? '0 : interrupt_status_reg) | pend_w) & interrupt_mask_reg);
		end
	end

	// Outputs registered; held when gated and no register is written, since the channel state is frozen.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			channel_wave_out <= 4'h0;
		end else begin
			channel_wave_out <= 4'(wave_w);
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (gen_hit) begin
			unique case (addr_in)
				`FCP_MODE_ADDR: rdata_next = generator_mode_reg;
				`FCP_SR_ADDR:   rdata_next = 32'(enable_reg);
				`FCP_IMR_ADDR:  rdata_next = 32'(interrupt_mask_reg);
				`FCP_ISR_ADDR:  rdata_next = 32'(interrupt_status_reg);
				default:        rdata_next = 32'h0000_0000;
			endcase
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (ch_hit[c]) begin
				unique case (ofs)
					`FCP_CH_CMR_OFS:  rdata_next = {21'h0, channel_mode_reg[c]};
					`FCP_CH_CHANNEL_DUTY_VALUE_OFS: rdata_next = {16'h0, channel_duty_reg[c]};
					`FCP_CH_CHANNEL_PERIOD_VALUE_OFS: rdata_next = {16'h0, channel_period_reg[c]};
					`FCP_CH_CCNT_OFS: rdata_next = {16'h0, count_w[c]};
					default:          rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h0000_0000;
		end else begin
			rdata_out <= rd_in ? rdata_next : 32'h0000_0000;
		end
	end
endmodule : fcp_top

// ### verification/fcp_top_properties.sv
`timescale 1ns/10ps
// Port-level checks of the register port, interrupt line and outputs.
module fcp_top_properties #(
	parameter int NUM_CH = 4
) (
	input wire logic        mclk_in,
	input wire logic        reset_n_in,
	input wire logic        clk_en_in,
	input wire logic [11:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        irq_out,
	input wire logic [3:0]  channel_wave_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	logic clr_evt;
	// A status read or a mask clear is the only thing that may drop the interrupt.
	assign clr_evt = (rd_in && addr_in == 12'h01c) || (wr_in && addr_in == 12'h014);
	a_rdata_idle_zero: assert property (
		!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside its window");
	a_unmapped_read_zero: assert property (
		rd_in && addr_in inside {[12'h020:12'h1fc], [12'h280:12'hfff]} |=> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_mode_read_back: assert property (
		wr_in && addr_in == 12'h000 ##1 rd_in && addr_in == 12'h000 |=>
		rdata_out == ($past(wdata_in, 2) & 32'h0fff_0fff)) else $error("mode read back wrong");
	a_enable_shows: assert property (
		wr_in && addr_in == 12'h004 ##1 rd_in && addr_in == 12'h00c |=>
		(rdata_out[3:0] & $past(wdata_in[3:0], 2)) == $past(wdata_in[3:0], 2)) else $error("enable lost");
	a_disable_shows: assert property (
		wr_in && addr_in == 12'h008 ##1 rd_in && addr_in == 12'h00c |=>
		(rdata_out[3:0] & $past(wdata_in[3:0], 2)) == 4'h0) else $error("disable lost");
	a_mask_set_shows: assert property (
		wr_in && addr_in == 12'h010 ##1 rd_in && addr_in == 12'h018 |=>
		(rdata_out[3:0] & $past(wdata_in[3:0], 2)) == $past(wdata_in[3:0], 2)) else $error("mask lost");
	a_irq_drop_cause: assert property (
		$fell(irq_out) |-> $past(clr_evt) || $past(clr_evt, 2) || $past(clr_evt, 3))
		else $error("interrupt dropped without clear");
	a_gated_wave_frozen: assert property (
		(!clk_en_in && !wr_in) [*3] |-> $stable(channel_wave_out)) else $error("output moved while gated");
	a_reset_wave_low: assert property (
		$rose(reset_n_in) |-> channel_wave_out == 4'h0) else $error("output not low after reset");
	c_irq_rise: cover property ($rose(irq_out));
	c_status_read: cover property (rd_in && addr_in == 12'h01c);
	c_gated_run: cover property (!clk_en_in [*3]);
endmodule : fcp_top_properties

bind fcp_top fcp_top_properties #(.NUM_CH(NUM_CH)) u_props (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .irq_out(irq_out), .channel_wave_out(channel_wave_out));

// ### verification/fcp_cpu_model.sv
`timescale 1ns/10ps
// Processor side of the register port: one strobe cycle per access, no waits.
module fcp_cpu_model (
	input  wire logic   clk_in,
	input  wire logic   irq_in,
	output logic [11:0] addr_out,
	output logic [31:0] wdata_out,
	output logic        wr_out,
	output logic        rd_out
);
	// Bus quiet from time zero so nothing is taken during reset.
	initial begin
		addr_out = 12'h000;
		wdata_out = 32'h0;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic write_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		rd_out <= 1'b0;
	endtask : write_reg
	task automatic read_reg(input logic [11:0] a);
		@(posedge clk_in);
		addr_out <= a;
		wr_out <= 1'b0;
		rd_out <= 1'b1;
	endtask : read_reg
	// Released lines toggle, so stale values are never mistaken for live ones.
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_in);
			wr_out <= 1'b0;
			rd_out <= 1'b0;
			addr_out <= ~addr_out;
			wdata_out <= ~wdata_out;
		end
	endtask : idle
	task automatic wait_irq(input int limit);
		for (int n = 0; n < limit && irq_in !== 1'b1; n++) @(negedge clk_in);
	endtask : wait_irq
endmodule : fcp_cpu_model

// ### verification/fcp_top_test.sv
`timescale 1ns/10ps
module fcp_top_test;
	logic        mclk_in;
	logic        reset_n_in;
	logic        clk_en_in;
	logic [11:0] addr_in;
	logic [31:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rdata_out;
	logic        irq_out;
	logic [3:0]  channel_wave_out;
	logic        rd_seen;
	logic [31:0] exp_q[$];
	logic [11:0] zero_addr[7] = '{12'h000, 12'h00c, 12'h018, 12'h01c, 12'h200, 12'h264, 12'h100};
	logic [31:0] v;
	int          miscompares;
	int          tests_run;
	int          seed;

	fcp_top #(.NUM_CH(4)) u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.irq_out(irq_out), .channel_wave_out(channel_wave_out));
	fcp_cpu_model u_cpu (.clk_in(mclk_in), .irq_in(irq_out), .addr_out(addr_in), .wdata_out(wdata_in),
		.wr_out(wr_in), .rd_out(rd_in));

	// Master clock, 100 ns period.
	initial mclk_in = 1'b0;
	always #50 mclk_in = ~mclk_in;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_cpu.read_reg(a);
	endtask : rd
	task automatic cfg(input logic [11:0] b, input logic [31:0] m, input logic [31:0] d, input logic [31:0] p);
		u_cpu.write_reg(b, m);
		u_cpu.write_reg(b + 12'h004, d);
		u_cpu.write_reg(b + 12'h008, p);
	endtask : cfg
	task automatic summarize;
		if (miscompares == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize

	// Read data is compared mid-cycle after the strobe edge, oldest note first.
	always @(posedge mclk_in) rd_seen <= rd_in;
	always @(negedge mclk_in) if (rd_seen === 1'b1) chk(rdata_out, exp_q.pop_front());

	// A hang is cut short well past the expected run length.
	initial begin
		#500000;
		miscompares++;
		summarize();
	end

	// Main sequence.
	initial begin
		seed = 17;
		reset_n_in = 1'b0;
		clk_en_in = 1'b1;
		repeat (10) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		foreach (zero_addr[i]) rd(zero_addr[i], 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & 32'h07ff_07ff;
			u_cpu.write_reg(12'h000, v);
			rd(12'h000, v);
		end
		u_cpu.write_reg(12'h000, 32'h0);
		// Polarity on a stopped channel shows at once.
		u_cpu.write_reg(12'h200, 32'h0000_0200);
		u_cpu.idle(4);
		@(negedge mclk_in);
		chk(channel_wave_out[0], 32'h1);
		// Each channel holds one extreme of duty and polarity, two of them centered.
		cfg(12'h200, 32'h0000_0000, 32'h6, 32'h6);
		cfg(12'h220, 32'h0000_0300, 32'h0, 32'h6);
		cfg(12'h240, 32'h0000_0100, 32'h0, 32'h6);
		cfg(12'h260, 32'h0000_0200, 32'h6, 32'h6);
		u_cpu.write_reg(12'h004, 32'hf);
		rd(12'h00c, 32'hf);
		u_cpu.write_reg(12'h260, 32'h0000_0400);
		rd(12'h260, 32'h0000_0600);
		u_cpu.idle(3);
		// Random gating must not disturb the fixed levels.
		repeat (40) begin
			@(posedge mclk_in);
			clk_en_in <= 1'($random(seed));
			@(negedge mclk_in);
			chk(channel_wave_out, 32'hc);
		end
		@(posedge mclk_in);
		clk_en_in <= 1'b1;
		u_cpu.write_reg(12'h008, 32'hf);
		rd(12'h00c, 32'h0);
		rd(12'h01c, 32'hf);
		rd(12'h01c, 32'h0);
		// Interrupt raised, cleared by reading, then masked.
		u_cpu.write_reg(12'h010, 32'h1);
		rd(12'h018, 32'h1);
		u_cpu.idle(2);
		@(negedge mclk_in);
		chk(irq_out, 32'h0);
		cfg(12'h200, 32'h0000_0000, 32'h2, 32'h4);
		u_cpu.write_reg(12'h004, 32'h1);
		u_cpu.idle(1);
		u_cpu.wait_irq(40);
		chk(irq_out, 32'h1);
		u_cpu.write_reg(12'h008, 32'h1);
		u_cpu.idle(2);
		rd(12'h01c, 32'h1);
		rd(12'h01c, 32'h0);
		u_cpu.idle(3);
		@(negedge mclk_in);
		chk(irq_out, 32'h0);
		u_cpu.write_reg(12'h014, 32'h1);
		rd(12'h018, 32'h0);
		// Update value waits for the period end, duty first, then period.
		cfg(12'h220, 32'h0000_0000, 32'h2, 32'h8);
		u_cpu.write_reg(12'h004, 32'h2);
		u_cpu.write_reg(12'h230, 32'h5);
		rd(12'h224, 32'h2);
		u_cpu.idle(20);
		rd(12'h224, 32'h5);
		u_cpu.write_reg(12'h220, 32'h0000_0400);
		u_cpu.write_reg(12'h230, 32'h9);
		rd(12'h228, 32'h8);
		u_cpu.idle(25);
		rd(12'h228, 32'h9);
		u_cpu.write_reg(12'h008, 32'h2);
		// Gated clock: writes land, the counter stands still.
		u_cpu.idle(1);
		clk_en_in <= 1'b0;
		u_cpu.write_reg(12'h004, 32'h1);
		u_cpu.write_reg(12'h000, 32'h0000_0203);
		rd(12'h000, 32'h0000_0203);
		u_cpu.idle(20);
		rd(12'h20c, 32'h0);
		u_cpu.idle(2);
		@(negedge mclk_in);
		chk(channel_wave_out[0], 32'h0);
		@(posedge mclk_in);
		clk_en_in <= 1'b1;
		u_cpu.idle(10);
		summarize();
	end
endmodule : fcp_top_test
